// file: pkg/btg_pkg.sv
package btg_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TONE = 8'h04;
  localparam logic [7:0] OFS_TIME = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_CONT = 1;
  localparam int CTRL_SPK_PWR = 2;
  localparam int CTRL_SPK_OE = 3;
  localparam int CTRL_SPK_GAIN = 4;
  localparam int CTRL_DAC_PWR = 5;

  // ----------------------------------------------------------------
  // Tone register fields
  // ----------------------------------------------------------------
  localparam int TONE_FREQ_LSB = 0;
  localparam int TONE_RLO_LSB = 2;
  localparam int TONE_RHI_LSB = 4;
  localparam int TONE_MODE_LSB = 6;
  localparam int TONE_FAM44 = 8;

  // ----------------------------------------------------------------
  // Time register fields
  // ----------------------------------------------------------------
  localparam int TIME_ON_LSB = 0;
  localparam int TIME_OFF_LSB = 8;
  localparam int TIME_REP_LSB = 16;
  localparam int TIME_LVL_LSB = 24;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [8:0] TONE_RESET = 9'h000;
  localparam logic [27:0] TIME_RESET = 28'h0000000;

  // ----------------------------------------------------------------
  // Timing reference modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BTG_REF_MASTER = 2'b00,
    BTG_REF_SLAVE = 2'b01,
    BTG_REF_EXT = 2'b10
  } btg_ref_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam real STEP_48_MS = 8.0;
  localparam real STEP_44_MS = 7.98;
  localparam int STEP_48_CYC = int'($floor(STEP_48_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int STEP_44_CYC = int'($floor(STEP_44_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TONE_48_HZ = 4000;
  localparam int TONE_44_HZ = 4009;
  localparam int TONE_48_HALF_CYC = 1000000000 / (2 * TONE_48_HZ * CLK_PERIOD_NS);
  localparam int TONE_44_HALF_CYC = 1000000000 / (2 * TONE_44_HZ * CLK_PERIOD_NS);

  // Half tone periods in eighths of a sample period
  localparam logic [8:0] EIGHTHS_PER_FS = 9'h008;
  localparam logic [8:0] HALF_2P75 = 9'h00b;
  localparam logic [8:0] HALF_5P5 = 9'h016;
  localparam logic [8:0] HALF_11 = 9'h02c;
  localparam logic [8:0] HALF_22 = 9'h058;
  localparam logic [8:0] HALF_44 = 9'h0b0;
  localparam logic [8:0] HALF_55 = 9'h0dc;

  localparam logic [1:0] FREQ_NA = 2'b11;

endpackage : btg_pkg

// file: logic/btg_div.sv
`timescale 1ns/100ps
module btg_div #(
  parameter int W = 18
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic [W-1:0] period_i,
  output logic tick_o
);

  logic [W-1:0] cnt_reg;

  // ----------------------------------------------------------------
  // Free-running divider, one tick each period_i cycles
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (clear_i) begin
      // Restart at one: the tick is seen a cycle late, so the first period stays full
      cnt_reg <= W'(1);
      tick_o <= 1'b0;
    end else if (cnt_reg >= period_i - W'(1)) begin
      cnt_reg <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule : btg_div

// file: logic/btg_top.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
module btg_top #(
  parameter int STEP_48_CYC = btg_pkg::STEP_48_CYC,
  parameter int STEP_44_CYC = btg_pkg::STEP_44_CYC,
  parameter int TONE_48_HALF_CYC = btg_pkg::TONE_48_HALF_CYC,
  parameter int TONE_44_HALF_CYC = btg_pkg::TONE_44_HALF_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic frame_clk_i,
  output logic spk_out_pos_o,
  output logic spk_out_neg_o,
  output logic [4:0] spk_atten_db_o,
  output logic spk_gain_o,
  output logic spk_amp_on_o,
  output logic dac_power_o
);

  typedef enum logic [1:0] {
    BTG_IDLE = 2'b00,
    BTG_ON = 2'b01,
    BTG_OFF = 2'b10,
    BTG_CONT = 2'b11
  } btg_state_t;

  logic [5:0] ctrl_reg;
  logic [8:0] tone_reg;
  logic [27:0] time_reg;
  btg_state_t state_reg;
  logic [7:0] step_cnt_reg;
  logic [6:0] rep_cnt_reg;
  logic done_reg;
  logic [2:0] fs_sync_reg;
  logic fs_level_reg;
  logic fs_tick_reg;
  logic [8:0] acc_reg;
  logic sq_reg;
  logic seq_clear;

  logic wr_en;
  logic acc_en;
  logic step_tick;
  logic mtone_tick;
  logic [17:0] step_period;
  logic [13:0] mtone_half;
  logic [8:0] fs_half;
  logic [9:0] acc_sum;
  logic [7:0] cur_limit;
  logic [1:0] freq_sel;
  logic [1:0] rate_lo;
  logic [1:0] rate_hi;
  logic [1:0] ref_mode;
  logic tone_on;
  logic spk_live;

  assign freq_sel = tone_reg[btg_pkg::TONE_FREQ_LSB +: 2];
  assign rate_lo = tone_reg[btg_pkg::TONE_RLO_LSB +: 2];
  assign rate_hi = tone_reg[btg_pkg::TONE_RHI_LSB +: 2];
  assign ref_mode = tone_reg[btg_pkg::TONE_MODE_LSB +: 2];
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i;

  // ----------------------------------------------------------------
  // APB slave, one wait state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= (paddr_i > btg_pkg::OFS_STAT) || (paddr_i[1:0] != 2'b00);
      prdata_o <= 32'h00000000;
      if (!pwrite_i) begin
        case (paddr_i)
          btg_pkg::OFS_CTRL: prdata_o <= {26'h0000000, ctrl_reg};
          btg_pkg::OFS_TONE: prdata_o <= {23'h000000, tone_reg};
          btg_pkg::OFS_TIME: prdata_o <= {4'h0, time_reg};
          btg_pkg::OFS_STAT: prdata_o <= {14'h0000, rep_cnt_reg, step_cnt_reg, 1'b0, state_reg};
          default: prdata_o <= 32'h00000000;
        endcase
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_reg <= btg_pkg::CTRL_RESET;
    end else if (wr_en && paddr_i == btg_pkg::OFS_CTRL) begin
      ctrl_reg <= pwdata_i[5:0];
      if (!pwdata_i[btg_pkg::CTRL_CONT] && ctrl_reg[btg_pkg::CTRL_START]) begin
        ctrl_reg[btg_pkg::CTRL_START] <= 1'b0;
      end
    end else if (done_reg) begin
      ctrl_reg[btg_pkg::CTRL_START] <= 1'b0;
    end
  end

  // Fields are taken as written; software keeps them still while busy
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tone_reg <= btg_pkg::TONE_RESET;
      time_reg <= btg_pkg::TIME_RESET;
    end else if (wr_en && paddr_i == btg_pkg::OFS_TONE) begin
      tone_reg <= pwdata_i[8:0];
    end else if (wr_en && paddr_i == btg_pkg::OFS_TIME) begin
      time_reg <= {pwdata_i[27:24], 1'b0, pwdata_i[22:0]};
    end
  end

  // ----------------------------------------------------------------
  // Sample-rate clock synchroniser and edge filter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fs_sync_reg <= 3'b000;
      fs_level_reg <= 1'b0;
      fs_tick_reg <= 1'b0;
    end else begin
      fs_sync_reg <= {fs_sync_reg[1:0], frame_clk_i};
      fs_tick_reg <= 1'b0;
      if (fs_sync_reg[1] == fs_sync_reg[2] && fs_sync_reg[2] != fs_level_reg) begin
        fs_level_reg <= fs_sync_reg[2];
        fs_tick_reg <= fs_sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Tone half period selection
  // ----------------------------------------------------------------
  always_comb begin
    fs_half = btg_pkg::HALF_2P75;
    if (ref_mode == btg_pkg::BTG_REF_EXT) begin
      case (rate_lo)
        2'b01: fs_half = (freq_sel == 2'b00) ? btg_pkg::HALF_2P75 :
                         (freq_sel == 2'b01) ? btg_pkg::HALF_5P5 : btg_pkg::HALF_11;
        2'b10: fs_half = (freq_sel == 2'b00) ? btg_pkg::HALF_55 :
                         (freq_sel == 2'b01) ? btg_pkg::HALF_11 : btg_pkg::HALF_22;
        default: fs_half = (freq_sel == 2'b00) ? btg_pkg::HALF_11 :
                           (freq_sel == 2'b01) ? btg_pkg::HALF_22 : btg_pkg::HALF_44;
      endcase
    end else begin
      case (freq_sel)
        2'b00: fs_half = btg_pkg::HALF_2P75;
        2'b01: fs_half = btg_pkg::HALF_5P5;
        default: fs_half = btg_pkg::HALF_11;
      endcase
      // Range code 11 is treated as the widest defined range
      fs_half = fs_half << ((rate_hi == 2'b11) ? 2'd2 : rate_hi);
    end
  end

  assign mtone_half = tone_reg[btg_pkg::TONE_FAM44] ?
                      (14'(TONE_44_HALF_CYC) << freq_sel) :
                      (14'(TONE_48_HALF_CYC) << freq_sel);
  assign step_period = tone_reg[btg_pkg::TONE_FAM44] ? 18'(STEP_44_CYC) : 18'(STEP_48_CYC);
  assign acc_sum = {1'b0, acc_reg} + {1'b0, btg_pkg::EIGHTHS_PER_FS};
  assign acc_en = fs_tick_reg && ref_mode != btg_pkg::BTG_REF_MASTER;
  // Timebase held while idle so the first on-time step is full length
  assign seq_clear = state_reg == BTG_IDLE;

  // ----------------------------------------------------------------
  // Timebase dividers
  // ----------------------------------------------------------------
  btg_div #(
    .W(18)
  ) u_step_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(seq_clear),
    .period_i(step_period),
    .tick_o(step_tick)
  );

  btg_div #(
    .W(14)
  ) u_tone_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(seq_clear),
    .period_i(mtone_half),
    .tick_o(mtone_tick)
  );

  // ----------------------------------------------------------------
  // Square wave, equal high and low halves in master mode; sample-clock modes vary half lengths by one tick
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i || seq_clear) begin
      acc_reg <= 9'h000;
      sq_reg <= 1'b0;
    end else if (ref_mode == btg_pkg::BTG_REF_MASTER) begin
      if (mtone_tick) begin
        sq_reg <= ~sq_reg;
      end
    end else if (acc_en) begin
      if (acc_sum >= {1'b0, fs_half}) begin
        acc_reg <= 9'(acc_sum - {1'b0, fs_half});
        sq_reg <= ~sq_reg;
      end else begin
        acc_reg <= acc_sum[8:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Beep sequencer
  // ----------------------------------------------------------------
  assign cur_limit = (state_reg == BTG_ON) ? time_reg[btg_pkg::TIME_ON_LSB +: 8] :
                     time_reg[btg_pkg::TIME_OFF_LSB +: 8];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_reg <= BTG_IDLE;
      step_cnt_reg <= 8'h00;
      rep_cnt_reg <= 7'h00;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state_reg)
        BTG_IDLE: begin
          step_cnt_reg <= 8'h00;
          rep_cnt_reg <= 7'h00;
          if (ctrl_reg[btg_pkg::CTRL_CONT]) begin
            state_reg <= BTG_CONT;
          end else if (ctrl_reg[btg_pkg::CTRL_START] && !done_reg) begin
            state_reg <= BTG_ON;
          end
        end
        BTG_ON, BTG_OFF: begin
          if (ctrl_reg[btg_pkg::CTRL_CONT]) begin
            state_reg <= BTG_CONT;
          end else if (!ctrl_reg[btg_pkg::CTRL_START]) begin
            state_reg <= BTG_IDLE;
          end else if (step_tick) begin
            if (step_cnt_reg != cur_limit) begin
              step_cnt_reg <= step_cnt_reg + 8'h01;
            end else if (state_reg == BTG_ON) begin
              step_cnt_reg <= 8'h00;
              state_reg <= BTG_OFF;
            end else if (rep_cnt_reg == time_reg[btg_pkg::TIME_REP_LSB +: 7]) begin
              state_reg <= BTG_IDLE;
              done_reg <= 1'b1;
            end else begin
              step_cnt_reg <= 8'h00;
              rep_cnt_reg <= rep_cnt_reg + 7'h01;
              state_reg <= BTG_ON;
            end
          end
        end
        BTG_CONT: begin
          if (!ctrl_reg[btg_pkg::CTRL_CONT]) begin
            state_reg <= BTG_IDLE;
          end
        end
        default: state_reg <= BTG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Speaker path
  // ----------------------------------------------------------------
  assign tone_on = (state_reg == BTG_ON || state_reg == BTG_CONT) && freq_sel != btg_pkg::FREQ_NA;
  assign spk_live = ctrl_reg[btg_pkg::CTRL_SPK_PWR] && ctrl_reg[btg_pkg::CTRL_SPK_OE];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      spk_out_pos_o <= 1'b0;
      spk_out_neg_o <= 1'b0;
    end else if (spk_live && tone_on) begin
      spk_out_pos_o <= sq_reg;
      spk_out_neg_o <= ~sq_reg;
    end else begin
      spk_out_pos_o <= 1'b0;
      spk_out_neg_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      spk_atten_db_o <= 5'h00;
      spk_gain_o <= 1'b0;
      spk_amp_on_o <= 1'b0;
      dac_power_o <= 1'b0;
    end else begin
      spk_gain_o <= ctrl_reg[btg_pkg::CTRL_SPK_GAIN];
      spk_amp_on_o <= ctrl_reg[btg_pkg::CTRL_SPK_PWR];
      dac_power_o <= ctrl_reg[btg_pkg::CTRL_DAC_PWR];
      case (time_reg[btg_pkg::TIME_LVL_LSB +: 4])
        4'h0: spk_atten_db_o <= 5'h00;
        4'h1: spk_atten_db_o <= 5'h03;
        4'h2: spk_atten_db_o <= 5'h06;
        4'h3: spk_atten_db_o <= 5'h09;
        4'h4: spk_atten_db_o <= 5'h0c;
        4'h5: spk_atten_db_o <= 5'h12;
        4'h6: spk_atten_db_o <= 5'h18;
        default: spk_atten_db_o <= 5'h1e;
      endcase
    end
  end

endmodule : btg_top

// file: bench/btg_spk_model.sv
`timescale 1ns/100ps
module btg_spk_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic pos_i,
  input wire logic neg_i,
  output int snd_o,
  output int bursts_o,
  output int hi_o,
  output int rises_o,
  output int span_o
);
  // ------
  // Listener on the bridged load
  // ------
  logic was_snd = 1'b0;
  logic was_pos = 1'b0;
  logic seen = 1'b0;
  int cnt = 0;
  wire logic now_snd = pos_i | neg_i;

  // Span runs from the first sounding cycle to the last one
  always @(posedge clk_i) begin
    if (clr_i) begin
      snd_o <= 0;
      bursts_o <= 0;
      hi_o <= 0;
      rises_o <= 0;
      span_o <= 0;
      cnt <= 0;
      seen <= 1'b0;
    end else begin
      snd_o <= snd_o + int'(now_snd);
      bursts_o <= bursts_o + int'(now_snd && !was_snd);
      hi_o <= hi_o + int'(pos_i);
      rises_o <= rises_o + int'(pos_i && !was_pos);
      if (now_snd || seen) cnt <= cnt + 1;
      if (now_snd) span_o <= cnt + 1;
      seen <= seen | now_snd;
    end
    was_snd <= now_snd;
    was_pos <= pos_i;
  end
endmodule : btg_spk_model

// file: bench/btg_top_sva.sv
`timescale 1ns/100ps
module btg_top_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic spk_out_pos_o,
  input wire logic spk_out_neg_o,
  input wire logic [4:0] spk_atten_db_o,
  input wire logic spk_amp_on_o
);
  // ------
  // Bus and speaker checks
  // ------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic acc = psel_i && penable_i && !pready_o;
  wire logic bad = paddr_i > 8'h0c || paddr_i[1:0] != 2'b00;

  a_ready_wait: assert property (acc |=> pready_o)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_ready_idle: assert property (!(psel_i && penable_i) |=> !pready_o)
    else $error("ready without access");
  a_err_decode: assert property (acc && bad |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && !bad |=> !pslverr_o)
    else $error("mapped access refused");
  a_unpowered_mute: assert property (!spk_amp_on_o && !$past(spk_amp_on_o) |->
    !spk_out_pos_o && !spk_out_neg_o) else $error("speaker driven while off");
  a_bridge_excl: assert property (!(spk_out_pos_o && spk_out_neg_o))
    else $error("both speaker outputs high");
  a_atten_code: assert property (spk_atten_db_o inside {5'h00, 5'h03, 5'h06,
    5'h09, 5'h0c, 5'h12, 5'h18, 5'h1e}) else $error("attenuation off table");
endmodule : btg_top_sva

bind btg_top btg_top_sva u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .spk_out_pos_o(spk_out_pos_o), .spk_out_neg_o(spk_out_neg_o),
  .spk_atten_db_o(spk_atten_db_o), .spk_amp_on_o(spk_amp_on_o));

// file: bench/btg_top_tb.sv
`timescale 1ns/100ps
module btg_top_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwrite = 1'b0;
  logic frame_clk = 1'b0;
  logic clr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, perr, pos, neg, amp, gain, dacp;
  logic [4:0] att;
  int failures = 0;
  int tests_run = 0;
  int snd, bursts, hi, rises, span;

  always #25 clk_i = ~clk_i;
  // Sample clock, unrelated in phase to clk_i
  always #205 frame_clk = ~frame_clk;

  btg_top #(.STEP_48_CYC(20), .STEP_44_CYC(20), .TONE_48_HALF_CYC(4),
    .TONE_44_HALF_CYC(5)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .frame_clk_i(frame_clk), .spk_out_pos_o(pos), .spk_out_neg_o(neg),
    .spk_atten_db_o(att), .spk_gain_o(gain), .spk_amp_on_o(amp), .dac_power_o(dacp));

  btg_spk_model u_spk (.clk_i(clk_i), .clr_i(clr), .pos_i(pos), .neg_i(neg),
    .snd_o(snd), .bursts_o(bursts), .hi_o(hi), .rises_o(rises), .span_o(span));

  // ------
  // Helpers
  // ------
  task summarize;
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task tmo;
    failures++;
    $display("BAD wait exp done got timeout");
    summarize;
  endtask : tmo

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask : chk

  task chkr(input string n, input int e, input int g);
    tests_run++;
    if (g < e - 1 || g > e + 1) begin
      failures++;
      $display("BAD %s exp %0d got %0d", n, e, g);
    end
  endtask : chkr

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 20) tmo;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // Settle, clear the listener, then count n edges
  task measure(input int n);
    repeat (4) @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : measure

  task hilen(output int n);
    int k;
    n = 0;
    k = 0;
    while (pos !== 1'b0 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    while (pos !== 1'b1 && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    while (pos === 1'b1 && k < 500) begin
      @(posedge clk_i);
      k++;
      n++;
    end
    if (k >= 500) tmo;
  endtask : hilen

  // ------
  // Scenarios
  // ------
  task t_regs;
    logic [31:0] w[4] = '{32'hfffffffc, 32'hffffffff, 32'hffffffff, 32'hffffffff};
    logic [31:0] x[4] = '{32'h0000003c, 32'h000001ff, 32'h0f7fffff, 32'h00000000};
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, r, e);
      chk("reset value", 32'h0, r);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), w[i]);
      rd(8'(4 * i), r);
      chk("field access", x[i], r);
    end
    for (int i = 0; i < 3; i++) wr(8'(4 * i), 32'h0);
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, r);
    apb(1'b1, 8'h06, 32'hffffffff, r, e);
    chk("unaligned err", 32'h1, 32'(e));
    $display("regs done");
  endtask : t_regs

  task t_level;
    logic [4:0] db[9] = '{5'h00, 5'h03, 5'h06, 5'h09, 5'h0c, 5'h12, 5'h18, 5'h1e, 5'h1e};
    for (int i = 0; i < 9; i++) begin
      wr(btg_pkg::OFS_TIME, {4'h0, 4'(i == 8 ? 15 : i), 24'h0});
      repeat (2) @(posedge clk_i);
      chk("atten", 32'(db[i]), 32'(att));
    end
    wr(btg_pkg::OFS_TIME, 32'h0);
    $display("level done");
  endtask : t_level

  task t_freq;
    int n;
    for (int f = 0; f < 3; f++) begin
      wr(btg_pkg::OFS_TONE, 32'(f));
      wr(btg_pkg::OFS_CTRL, 32'h2e);
      hilen(n);
      chk("half period", 32'(4 << f), 32'(n));
      wr(btg_pkg::OFS_CTRL, 32'h0);
    end
    wr(btg_pkg::OFS_TONE, 32'h100);
    wr(btg_pkg::OFS_CTRL, 32'h2e);
    hilen(n);
    chk("half period 44k", 32'd5, 32'(n));
    wr(btg_pkg::OFS_CTRL, 32'h0);
    wr(btg_pkg::OFS_TONE, 32'h3);
    wr(btg_pkg::OFS_CTRL, 32'h2e);
    measure(100);
    chk("code 3 sound", 32'h0, 32'(snd));
    wr(btg_pkg::OFS_CTRL, 32'h0);
    $display("freq done");
  endtask : t_freq

  task t_fs;
    logic [31:0] tn[7] = '{32'h40, 32'h62, 32'h51, 32'h88, 32'h85, 32'h8e, 32'h80};
    int ex[7] = '{80, 5, 20, 4, 40, 5, 20};
    for (int i = 0; i < 7; i++) begin
      wr(btg_pkg::OFS_TONE, tn[i]);
      wr(btg_pkg::OFS_CTRL, 32'h2e);
      measure(1804);
      chkr("tone periods", ex[i], rises);
      wr(btg_pkg::OFS_CTRL, 32'h0);
    end
    wr(btg_pkg::OFS_TONE, 32'h0);
    $display("sample clock modes done");
  endtask : t_fs

  task t_beep(input int on, input int off, input int rep);
    logic [31:0] r;
    int k;
    int s;
    s = (rep + 1) * (on + 1) * 20;
    wr(btg_pkg::OFS_TIME, {9'h0, 7'(rep), 8'(off), 8'(on)});
    measure(0);
    wr(btg_pkg::OFS_CTRL, 32'h2d);
    k = 0;
    do begin
      rd(btg_pkg::OFS_CTRL, r);
      k++;
    end while (r[0] !== 1'b0 && k < 5000);
    if (k >= 5000) tmo;
    chk("start cleared", 32'h2c, r);
    chk("sound cycles", 32'(s), 32'(snd));
    chk("bursts", 32'(rep + 1), 32'(bursts));
    chk("span", 32'(s + rep * (off + 1) * 20), 32'(span));
    chk("high cycles", 32'(s / 2), 32'(hi));
    $display("beep %0d %0d %0d done", on, off, rep);
  endtask : t_beep

  task t_cont;
    logic [31:0] r;
    wr(btg_pkg::OFS_CTRL, 32'h2f);
    measure(200);
    chk("cont sound", 32'd200, 32'(snd));
    wr(btg_pkg::OFS_CTRL, 32'h2d);
    rd(btg_pkg::OFS_CTRL, r);
    chk("start forced", 32'h2c, r);
    measure(50);
    chk("cont stopped", 32'h0, 32'(snd));
    wr(btg_pkg::OFS_CTRL, 32'h0);
    $display("cont done");
  endtask : t_cont

  task t_gate;
    logic [31:0] c[4] = '{32'h3a, 32'h36, 32'h1e, 32'h0e};
    for (int i = 0; i < 4; i++) begin
      wr(btg_pkg::OFS_CTRL, c[i]);
      measure(100);
      chk("amp on", 32'(c[i][2]), 32'(amp));
      chk("gain", 32'(c[i][4]), 32'(gain));
      chk("dac power", 32'(c[i][5]), 32'(dacp));
      chk("gated", (c[i][2] & c[i][3]) ? 32'd100 : 32'd0, 32'(snd));
      wr(btg_pkg::OFS_CTRL, 32'h0);
    end
    $display("gate done");
  endtask : t_gate

  initial begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs;
    t_level;
    t_freq;
    t_fs;
    t_beep(1, 3, 0);
    t_beep(3, 1, 2);
    t_beep(3, 1, 127);
    t_cont;
    t_gate;
    summarize;
  end
endmodule : btg_top_tb
